// ---- src/dcb_serial_unit.sv ----
// d-channel basic receiver and transmitter with register port
//
// Functional notes
// - rx and tx each buffered through a 32-byte fifo
// - message mode frames whole message: start, data, optional parity, stop
// - fifo-level mode frames each byte, or sends data unframed
// - channel rate is 1, 2 or 8 bits per tdm frame
// - mode bit 1 selects message-length mode, 0 fifo-level mode
// - receiver takes the channel byte chosen by connect memory 70
// - read of offset 43 returns and removes next rx fifo byte
// - rx bit order puts first received bit on d0 or d7
// - message mode rx ignores framing bit, strips start and stop
// - message mode stores after first zero; parity bit checked if enabled
// - framed fifo mode hunts first zero; unframed stores at once, no parity
// - message and error interrupts, each gated; overrun/parity/stop flags share the error enable
// - rx interrupt at message end, or when fifo count meets threshold
// - byte arriving at full rx fifo sets overrun and interrupts
// - missing stop bit and parity mismatch set error flags
// - write of offset 44 loads one byte into tx fifo, 32 max
// - tx bits appear as data memory byte 70 for any channel
// - tx bit order comes from the rx threshold register
// - message mode tx wraps message in start/stop, optional parity
// - fifo mode tx unframed, or framed per byte with optional parity
// - unused bit slots after a message are filled with stop value
// - tx interrupt on completion, or fifo empty / three-quarter empty
// - tx interrupt enable gates all transmitter interrupts
`timescale 1ns/100ps
`include "dcb_consts.svh"
module dcb_serial_unit import dcb_pkg::*; #(
    parameter int FIFO_DEPTH = `DCB_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    input wire logic frame_in,
    input wire logic [7:0] rx_chan_byte_in,
    output logic [7:0] tx_chan_byte_out,
    output logic irq_out
);
    localparam int CW = $clog2(FIFO_DEPTH + 1);

    if (FIFO_DEPTH < 8 || FIFO_DEPTH > 64) begin : g_bad_depth
        $error("fifo depth must lie between 8 and 64");
    end

    ////////////////////////////////////////////////////////////////////////
    // registers and decode

    logic [7:0] rx_ctrl_reg;
    logic [7:0] tx_ctrl_reg;
    logic [7:0] rx_thr_reg;
    logic [7:0] msg_len_reg;
    dcb_irq_t irq_en_reg;
    dcb_irq_t irq_stat_reg;
    dcb_rx_err_t rx_err_reg;
    dcb_rx_ctrl_t rxc;
    dcb_tx_ctrl_t txc;
    dcb_irq_t irq_set;
    dcb_rx_err_t err_set;
    logic tx_order;

    assign rxc = dcb_rx_ctrl_t'(rx_ctrl_reg);
    assign txc = dcb_tx_ctrl_t'(tx_ctrl_reg);
    assign tx_order = rx_thr_reg[`DCB_THR_ORDER_BIT];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic [3:0] slot_bits(input logic [1:0] rate);
        unique case (rate)
            `DCB_RATE_1: slot_bits = 4'h1;
            `DCB_RATE_2: slot_bits = 4'h2;
            default: slot_bits = 4'h8;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // fifos

    logic rx_push;
    logic [7:0] rx_push_data;
    logic rx_pop;
    logic [7:0] rx_head;
    logic [CW-1:0] rx_cnt;
    logic [CW-1:0] rx_cnt_prev_reg;
    logic rx_full;
    logic rx_empty;
    logic tx_push;
    logic tx_pop;
    logic [7:0] tx_head;
    logic [CW-1:0] tx_cnt;
    logic [CW-1:0] tx_cnt_prev_reg;
    logic tx_full;
    logic tx_empty;

    assign rx_pop = reg_rd_in && hit(reg_addr_in, `DCB_ADDR_RX_FIFO);
    assign tx_push = reg_wr_in && hit(reg_addr_in, `DCB_ADDR_TX_FIFO);

    dcb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) u_rx_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .push_in(rx_push),
        .push_data_in(rx_push_data),
        .pop_in(rx_pop),
        .head_out(rx_head),
        .count_out(rx_cnt),
        .full_out(rx_full),
        .empty_out(rx_empty)
    );

    dcb_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .CW(CW)) u_tx_fifo (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .push_in(tx_push),
        .push_data_in(reg_wdata_in),
        .pop_in(tx_pop),
        .head_out(tx_head),
        .count_out(tx_cnt),
        .full_out(tx_full),
        .empty_out(tx_empty)
    );

    ////////////////////////////////////////////////////////////////////////
    // bit slots of the channel byte, one per clock after the frame strobe

    logic [3:0] slot_reg;
    logic [7:0] rx_latch_reg;
    logic [7:0] tx_stage_reg;
    logic [2:0] slot_pos;
    logic slot_live;
    logic rx_take;
    logic tx_take;
    logic rx_bit;
    logic tx_bit;

    assign slot_live = (slot_reg != `DCB_SLOT_IDLE);
    assign slot_pos = 3'h7 - slot_reg[2:0];
    assign rx_bit = rx_latch_reg[slot_pos];
    assign rx_take = slot_live && rxc.enable
        && (slot_reg < slot_bits(rxc.rate));
    assign tx_take = slot_live && (slot_reg < slot_bits(txc.rate));

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            slot_reg <= `DCB_SLOT_IDLE;
            rx_latch_reg <= 8'hFF;
            tx_stage_reg <= 8'hFF;
            tx_chan_byte_out <= 8'hFF;
        end else if (frame_in) begin
            slot_reg <= 4'h0;
            rx_latch_reg <= rx_chan_byte_in;
            tx_chan_byte_out <= tx_stage_reg;
        end else if (slot_live) begin
            slot_reg <= slot_reg + 4'h1;
            tx_stage_reg[slot_pos] <= tx_take ? tx_bit : 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver

    dcb_rx_state_t rx_state_reg;
    dcb_rx_state_t rx_state_next;
    logic [7:0] rx_sr_reg;
    logic [2:0] rx_bcnt_reg;
    logic [7:0] rx_mcnt_reg;
    logic rx_par_reg;
    logic [7:0] rx_shift;
    logic rx_framed;
    logic rx_byte_end;
    logic rx_msg_end;
    logic rx_store;

    assign rx_framed = rxc.msg_length_irq_mode || rxc.framing_bits_on;
    assign rx_shift = rxc.bit_order ? {rx_sr_reg[6:0], rx_bit}
                                    : {rx_bit, rx_sr_reg[7:1]};
    assign rx_byte_end = (rx_bcnt_reg == 3'h7);
    assign rx_msg_end = rxc.msg_length_irq_mode
        && (rx_mcnt_reg == msg_len_reg);
    assign rx_store = rx_take && (rx_state_reg == RX_DATA)
        && (rx_byte_end || rx_msg_end);
    assign rx_push = rx_store && !rx_full;
    assign rx_push_data = rx_shift;

    always_comb begin
        rx_state_next = rx_state_reg;
        unique case (rx_state_reg)
            RX_HUNT: begin
                if (!rx_framed) begin
                    rx_state_next = RX_DATA;
                end else if (rx_take && !rx_bit) begin
                    rx_state_next = RX_DATA;
                end
            end
            RX_DATA: begin
                if (rx_take && rx_framed) begin
                    if (rx_msg_end || (!rxc.msg_length_irq_mode
                                       && rx_byte_end)) begin
                        rx_state_next = rxc.parity_on ? RX_PAR : RX_STOP;
                    end
                end
            end
            RX_PAR: begin
                if (rx_take) begin
                    rx_state_next = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_take) begin
                    rx_state_next = RX_HUNT;
                end
            end
        endcase
        if (!rxc.enable) begin
            rx_state_next = RX_HUNT;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rx_state_reg <= RX_HUNT;
            rx_sr_reg <= 8'h00;
            rx_bcnt_reg <= 3'h0;
            rx_mcnt_reg <= 8'h00;
            rx_par_reg <= 1'b0;
        end else begin
            rx_state_reg <= rx_state_next;
            if (rx_state_reg == RX_HUNT) begin
                rx_bcnt_reg <= 3'h0;
                rx_mcnt_reg <= 8'h00;
                rx_par_reg <= 1'b0;
            end else if (rx_take && rx_state_reg == RX_DATA) begin
                rx_sr_reg <= rx_shift;
                rx_bcnt_reg <= rx_bcnt_reg + 3'h1;
                rx_mcnt_reg <= rx_mcnt_reg + 8'h01;
                rx_par_reg <= rx_par_reg ^ rx_bit;
            end
        end
    end

    always_comb begin
        err_set.overrun = rx_store && rx_full;
        err_set.parity_err = rx_take && (rx_state_reg == RX_PAR)
            && (rx_par_reg != rx_bit);
        err_set.stop_err = rx_take && (rx_state_reg == RX_STOP)
            && !rx_bit;
    end

    ////////////////////////////////////////////////////////////////////////
    // transmitter

    dcb_tx_state_t tx_state_reg;
    dcb_tx_state_t tx_state_next;
    logic [7:0] tx_sr_reg;
    logic [2:0] tx_bcnt_reg;
    logic tx_par_reg;
    logic tx_framed;
    logic tx_load;
    logic tx_done;

    assign tx_framed = txc.msg_length_irq_mode || txc.framing_bits_on;
    assign tx_pop = tx_load;

    always_comb begin
        tx_state_next = tx_state_reg;
        tx_bit = 1'b1;
        tx_load = 1'b0;
        tx_done = 1'b0;
        unique case (tx_state_reg)
            TX_IDLE: begin
                if (tx_take && txc.launch_tx && !tx_empty) begin
                    tx_bit = !tx_framed;
                    tx_load = 1'b1;
                    tx_state_next = TX_DATA;
                end
            end
            TX_START: begin
                if (tx_take) begin
                    tx_bit = 1'b0;
                    tx_load = 1'b1;
                    tx_state_next = TX_DATA;
                end
            end
            TX_DATA: begin
                if (tx_take) begin
                    tx_bit = tx_order ? tx_sr_reg[7] : tx_sr_reg[0];
                    if (tx_bcnt_reg == 3'h7) begin
                        if (tx_framed && !txc.msg_length_irq_mode) begin
                            tx_state_next = txc.parity_on ? TX_PAR
                                                          : TX_STOP;
                        end else if (!tx_empty) begin
                            tx_load = 1'b1;
                        end else if (tx_framed) begin
                            tx_state_next = txc.parity_on ? TX_PAR
                                                          : TX_STOP;
                        end else begin
                            tx_state_next = TX_IDLE;
                            tx_done = 1'b1;
                        end
                    end
                end
            end
            TX_PAR: begin
                if (tx_take) begin
                    tx_bit = tx_par_reg;
                    tx_state_next = TX_STOP;
                end
            end
            TX_STOP: begin
                if (tx_take) begin
                    tx_bit = 1'b1;
                    if (!txc.msg_length_irq_mode && !tx_empty) begin
                        tx_state_next = TX_START;
                    end else begin
                        tx_state_next = TX_IDLE;
                        tx_done = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tx_state_reg <= TX_IDLE;
            tx_sr_reg <= 8'hFF;
            tx_bcnt_reg <= 3'h0;
            tx_par_reg <= 1'b0;
        end else begin
            tx_state_reg <= tx_state_next;
            if (tx_load) begin
                tx_sr_reg <= tx_head;
                tx_bcnt_reg <= 3'h0;
                if (tx_state_reg != TX_DATA || !txc.msg_length_irq_mode) begin
                    tx_par_reg <= 1'b0;
                end else begin
                    tx_par_reg <= tx_par_reg ^ tx_bit;
                end
            end else if (tx_take && tx_state_reg == TX_DATA) begin
                tx_sr_reg <= tx_order ? {tx_sr_reg[6:0], 1'b1}
                                      : {1'b1, tx_sr_reg[7:1]};
                tx_bcnt_reg <= tx_bcnt_reg + 3'h1;
                tx_par_reg <= tx_par_reg ^ tx_bit;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt events

    always_comb begin
        irq_set.rx_msg_irq = rxc.msg_length_irq_mode
            ? (rx_take && rx_state_reg == RX_STOP)
            : (rx_cnt == CW'(rx_thr_reg[`DCB_THR_LVL_MSB:0])
               && rx_cnt_prev_reg != rx_cnt);
        irq_set.rx_error_irq = |err_set;
        if (txc.tx_irq_cause_sel) begin
            irq_set.tx_irq = tx_done;
        end else if (txc.tx_fifo_irq_level) begin
            irq_set.tx_irq = (tx_cnt == CW'(FIFO_DEPTH / 4))
                && (tx_cnt_prev_reg > tx_cnt);
        end else begin
            irq_set.tx_irq = tx_empty && (tx_cnt_prev_reg != '0);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rx_cnt_prev_reg <= '0;
            tx_cnt_prev_reg <= '0;
        end else begin
            rx_cnt_prev_reg <= rx_cnt;
            tx_cnt_prev_reg <= tx_cnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes; hardware set wins over write-one-to-clear

    logic wr_irq_stat;
    logic wr_rx_err;

    assign wr_irq_stat = reg_wr_in && hit(reg_addr_in, `DCB_ADDR_IRQ_STAT);
    assign wr_rx_err = reg_wr_in && hit(reg_addr_in, `DCB_ADDR_RX_ERR);

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            rx_ctrl_reg <= `DCB_CTRL_RESET;
            rx_thr_reg <= `DCB_THR_RESET;
            msg_len_reg <= `DCB_MSG_LEN_RESET;
            irq_en_reg <= `DCB_IRQ_EN_RESET;
        end else if (reg_wr_in) begin
            if (hit(reg_addr_in, `DCB_ADDR_RX_CTRL)) begin
                rx_ctrl_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `DCB_ADDR_RX_THR)) begin
                rx_thr_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `DCB_ADDR_MSG_LEN)) begin
                msg_len_reg <= reg_wdata_in;
            end
            if (hit(reg_addr_in, `DCB_ADDR_IRQ_EN)) begin
                irq_en_reg <= dcb_irq_t'(reg_wdata_in[2:0]);
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tx_ctrl_reg <= `DCB_CTRL_RESET;
        end else begin
            if (reg_wr_in && hit(reg_addr_in, `DCB_ADDR_TX_CTRL)) begin
                tx_ctrl_reg <= reg_wdata_in;
            end else if (tx_done) begin
                tx_ctrl_reg[0] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_stat_reg <= '0;
            rx_err_reg <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg
                & ~(wr_irq_stat ? dcb_irq_t'(reg_wdata_in[2:0]) : '0))
                | irq_set;
            rx_err_reg <= (rx_err_reg
                & ~(wr_rx_err ? dcb_rx_err_t'(reg_wdata_in[2:0]) : '0))
                | err_set;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(irq_stat_reg & irq_en_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle after the strobe

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `DCB_ADDR_RX_CTRL: reg_rdata_out <= rx_ctrl_reg;
                `DCB_ADDR_RX_THR: reg_rdata_out <= rx_thr_reg;
                `DCB_ADDR_RX_FIFO: reg_rdata_out <= rx_empty ? 8'h00
                                                            : rx_head;
                `DCB_ADDR_TX_CTRL: reg_rdata_out <= tx_ctrl_reg;
                `DCB_ADDR_RX_ERR: reg_rdata_out <= {5'h00, rx_err_reg};
                `DCB_ADDR_IRQ_STAT: reg_rdata_out <= {5'h00, irq_stat_reg};
                `DCB_ADDR_IRQ_EN: reg_rdata_out <= {5'h00, irq_en_reg};
                `DCB_ADDR_MSG_LEN: reg_rdata_out <= msg_len_reg;
                `DCB_ADDR_CHAN_STAT: reg_rdata_out <= {tx_full, rx_empty,
                                                       (6)'(rx_cnt)};
                default: reg_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule

// ---- src/dcb_consts.svh ----
// register offsets, field positions and fixed counts of the d-channel unit
`ifndef DCB_CONSTS_SVH
`define DCB_CONSTS_SVH

`define DCB_ADDR_RX_CTRL 8'h41
`define DCB_ADDR_RX_THR 8'h42
`define DCB_ADDR_RX_FIFO 8'h43
`define DCB_ADDR_TX_FIFO 8'h44
`define DCB_ADDR_TX_CTRL 8'h45
`define DCB_ADDR_RX_ERR 8'h46
`define DCB_ADDR_IRQ_STAT 8'h47
`define DCB_ADDR_IRQ_EN 8'h48
`define DCB_ADDR_MSG_LEN 8'h49
`define DCB_ADDR_CHAN_STAT 8'h4A

`define DCB_CTRL_RESET 8'h00
`define DCB_THR_RESET 8'h00
`define DCB_MSG_LEN_RESET 8'h07
`define DCB_IRQ_EN_RESET 3'h0

`define DCB_THR_ORDER_BIT 7
`define DCB_THR_LVL_MSB 5
`define DCB_RATE_1 2'h0
`define DCB_RATE_2 2'h1
`define DCB_RATE_8 2'h2
`define DCB_SLOT_BITS 8
`define DCB_SLOT_IDLE 4'h8
`define DCB_FIFO_DEPTH 32

`endif

// ---- src/dcb_pkg.sv ----
// types of the d-channel basic receive/transmit unit
package dcb_pkg;

    typedef struct packed {
        logic spare;
        logic bit_order;
        logic [1:0] rate;
        logic msg_length_irq_mode;
        logic framing_bits_on;
        logic parity_on;
        logic enable;
    } dcb_rx_ctrl_t;

    typedef struct packed {
        logic tx_fifo_irq_level;
        logic tx_irq_cause_sel;
        logic [1:0] rate;
        logic msg_length_irq_mode;
        logic framing_bits_on;
        logic parity_on;
        logic launch_tx;
    } dcb_tx_ctrl_t;

    typedef struct packed {
        logic tx_irq;
        logic rx_error_irq;
        logic rx_msg_irq;
    } dcb_irq_t;

    typedef struct packed {
        logic stop_err;
        logic parity_err;
        logic overrun;
    } dcb_rx_err_t;

    typedef enum logic [1:0] {RX_HUNT, RX_DATA, RX_PAR, RX_STOP} dcb_rx_state_t;
    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } dcb_tx_state_t;

endpackage

// ---- src/dcb_fifo.sv ----
// byte fifo with count, used for both directions
`timescale 1ns/100ps
module dcb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic push_in,
    input wire logic [WIDTH-1:0] push_data_in,
    input wire logic pop_in,
    output logic [WIDTH-1:0] head_out,
    output logic [CW-1:0] count_out,
    output logic full_out,
    output logic empty_out
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("fifo depth must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [PW-1:0] wr_ptr_reg;
    logic [PW-1:0] rd_ptr_reg;
    logic [CW-1:0] count_reg;
    logic do_push;
    logic do_pop;

    assign empty_out = (count_reg == '0);
    assign full_out = (count_reg == CW'(DEPTH));
    assign do_pop = pop_in && !empty_out;
    assign do_push = push_in && (!full_out || do_pop);
    assign head_out = mem_reg[rd_ptr_reg];
    assign count_out = count_reg;

    always_ff @(posedge clk_in) begin
        if (do_push) begin
            mem_reg[wr_ptr_reg] <= push_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_reg <= wr_ptr_reg + PW'(1);
            end
            if (do_pop) begin
                rd_ptr_reg <= rd_ptr_reg + PW'(1);
            end
            if (do_push && !do_pop) begin
                count_reg <= count_reg + CW'(1);
            end else if (do_pop && !do_push) begin
                count_reg <= count_reg - CW'(1);
            end
        end
    end
endmodule

// ---- verification/dcb_serial_unit_chk.sv ----
// port assertions for the d-channel serial unit
`timescale 1ns/100ps
module dcb_serial_unit_chk #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic frame_in,
    input wire logic [7:0] rx_chan_byte_in,
    input wire logic [7:0] tx_chan_byte_out,
    input wire logic irq_out
);
    logic [7:0] txc_reg;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            txc_reg <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == 8'h45) begin
            txc_reg <= reg_wdata_in;
        end
    end
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);
    reset_vals_a: assert property (disable iff (1'b0) !resetn_in |=>
        reg_rdata_out == 8'h00 && tx_chan_byte_out == 8'hFF && !irq_out)
        else $error("outputs not at reset values");
    rdata_hold_a: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
        else $error("read data moved without a read");
    tx_frame_a: assert property (!frame_in |=> $stable(tx_chan_byte_out))
        else $error("channel byte moved off the frame");
    unmapped_rd_a: assert property (reg_rd_in && (reg_addr_in < 8'h41 ||
        reg_addr_in > 8'h4A) |=> reg_rdata_out == 8'h00)
        else $error("unmapped read not zero");
    irq_gate_a: assert property (reg_wr_in && reg_addr_in == 8'h48 &&
        reg_wdata_in[2:0] == 3'h0 ##1 !(reg_wr_in && reg_addr_in == 8'h48)
        |=> !irq_out) else $error("irq with all enables off");
    pad_one_a: assert property (frame_in && txc_reg[5:4] == 2'h0 |=>
        tx_chan_byte_out[6:0] == 7'h7F) else $error("rate one pad not ones");
    pad_two_a: assert property (frame_in && txc_reg[5:4] == 2'h1 |=>
        tx_chan_byte_out[5:0] == 6'h3F) else $error("rate two pad not ones");
    tx_idle_a: assert property (frame_in && !txc_reg[0] |=>
        tx_chan_byte_out == 8'hFF) else $error("idle channel not ones");
    cover property (frame_in && txc_reg[0]);
    cover property ($rose(irq_out));
    cover property (reg_rd_in && reg_addr_in == 8'h43);
endmodule

bind dcb_serial_unit dcb_serial_unit_chk #(.FIFO_DEPTH(FIFO_DEPTH)) chk (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
    .frame_in(frame_in), .rx_chan_byte_in(rx_chan_byte_in),
    .tx_chan_byte_out(tx_chan_byte_out), .irq_out(irq_out));

// ---- verification/dcb_tdm_model.sv ----
// switch memory side: frame strobe, channel 70 looped back to the receiver
`timescale 1ns/100ps
module dcb_tdm_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [7:0] tx_byte_in,
    output logic frame_out,
    output logic [7:0] rx_byte_out
);
    logic [3:0] tick_reg;
    logic [7:0] held_reg;
    always_ff @(posedge clk_in) begin
        if (!resetn_in) begin
            tick_reg <= 4'h0;
            held_reg <= 8'hFF;
        end else begin
            tick_reg <= tick_reg + 4'h1;
            if (frame_out) begin
                held_reg <= tx_byte_in;
            end
        end
    end
    // one strobe per 16 clocks, above the minimum spacing
    assign frame_out = tick_reg == 4'hF;
    // byte valid only at the strobe, inverted elsewhere
    assign rx_byte_out = frame_out ? held_reg : ~held_reg;
endmodule

// ---- verification/dcb_serial_unit_test.sv ----
// self-checking bench for the d-channel serial unit
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
    fail_count++; $display("BAD %0t got %h want %h", $time, a, b); end end
module dcb_serial_unit_test import dcb_pkg::*;;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata, tx_byte, rx_byte;
    logic frame, irq;
    int fail_count = 0;
    int comparisons = 0;
    logic [7:0] ra [9] = '{8'h41, 8'h42, 8'h43, 8'h45, 8'h46, 8'h48,
        8'h49, 8'h4A, 8'h50};
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h07, 8'h40, 8'h00};
    logic [7:0] mv [5] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h0A};
    dcb_serial_unit #(.FIFO_DEPTH(32)) dut (.clk_in(clk_in),
        .resetn_in(resetn_in), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
        .frame_in(frame), .rx_chan_byte_in(rx_byte),
        .tx_chan_byte_out(tx_byte), .irq_out(irq));
    dcb_tdm_model tdm (.clk_in(clk_in), .resetn_in(resetn_in),
        .tx_byte_in(tx_byte), .frame_out(frame), .rx_byte_out(rx_byte));
    initial forever #2 clk_in = ~clk_in;
    task automatic step();
        @(posedge clk_in);
        #1;
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic do_reset();
        resetn_in = 1'b0;
        repeat (5) step();
        resetn_in = 1'b1;
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step();
        wr = 1'b0;
        step();
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        step();
        rd = 1'b0;
        d = rdata;
        step();
    endtask
    task automatic next_frame();
        int n;
        n = 0;
        while (frame !== 1'b1) begin
            step();
            n++;
            if (n > 40) begin
                fail_count++;
                close_out();
            end
        end
        step();
    endtask
    function automatic logic [1:0] tail(input logic [7:0] b, input logic p);
        return p ? {^b, 1'b1} : 2'b11;
    endfunction
    initial begin
        logic [7:0] d, b, ctl;
        logic [47:0] bits;
        int k, off;
        void'($urandom(32'h54E3));
        do_reset();
        foreach (ra[i]) begin
            rd_reg(ra[i], d);
            `CHK(d, rv[i])
        end
        for (int i = 0; i < 33; i++) begin
            wr_reg(8'h44, 8'($urandom));
            if (i == 30 || i == 32) begin
                rd_reg(8'h4A, d);
                `CHK(d[7], i == 32)
            end
        end
        $display("test reset and fill done");
        do_reset();
        wr_reg(8'h48, 8'h04);
        foreach (mv[m]) for (int r = 0; r < 3; r++) begin
            k = r == 0 ? 1 : (r == 1 ? 2 : 8);
            ctl = 8'h41 | mv[m] | 8'(r * 16);
            wr_reg(8'h41, mv[m] == 8'h02 ? 8'h00 : ctl & 8'h3F);
            wr_reg(8'h45, ctl);
            b = 8'($urandom) & (mv[m] == 8'h02 ? 8'hFE : 8'hFF);
            wr_reg(8'h44, b);
            for (int f = 0; f < 48 / k; f++) begin
                next_frame();
                for (int j = 0; j < k; j++) bits[f * k + j] = tx_byte[7 - j];
            end
            off = 0;
            while (bits[off] !== 1'b0 && off < 36) off++;
            if (mv[m] != 8'h02) off++;
            for (int j = 0; j < 8; j++) d[j] = bits[off + j];
            `CHK(d, b)
            if (mv[m] != 8'h02) begin
                `CHK({bits[off+8], bits[off+9]}, tail(b, mv[m][1]))
                rd_reg(8'h43, d);
                `CHK(d, b)
                rd_reg(8'h46, d);
                `CHK(d, 8'h00)
            end
            `CHK(irq, 1'b1)
            wr_reg(8'h47, 8'h07);
            wr_reg(8'h41, 8'h00);
            $display("test mode %h rate %0d done", mv[m], r);
        end
        wr_reg(8'h48, 8'h00);
        repeat (2) step();
        close_out();
    end
endmodule
